// file: src/cnnlsf_pkg.sv
// Purpose: shared constants for the layer sum feed control block
// Assumes: apb, 32-bit data, one aligned word per register
// Notes: reset values of all fields are zero
package cnnlsf_pkg;
   localparam logic [11:0] CNNLSF_LCW0_OFFSET = 12'h590;
   localparam int CNNLSF_WIDE_BIT = 16;
   localparam int CNNLSF_FEED_HI = 15;
   localparam int CNNLSF_FEED_LO = 12;
   localparam int CNNLSF_GSRC_BIT = 11;
   localparam int CNNLSF_LOW_HI = 10;
   localparam logic [31:0] CNNLSF_LCW0_WMASK = 32'h0001_FFFF;
   localparam logic [31:0] CNNLSF_LCW0_RESET = 32'h0000_0000;
   localparam int CNNLSF_PSUM_W = 26;
   localparam int CNNLSF_ACC_W = 32;
   localparam int CNNLSF_SDATA_W = 32;
   localparam int CNNLSF_ADDR_W = 17;
   localparam int CNNLSF_NPROC = 4;
endpackage

// file: src/cnnlsf_feed_add.sv
// Purpose: gated sign-extending adder of one neighbour partial sum
// Assumes: partial sums are signed two's complement
// Notes: combinational, instantiated once per neighbour
`timescale 1ns/1ps
`default_nettype none
module cnnlsf_feed_add
   import cnnlsf_pkg::*;
(
   // operands
   input wire logic en,
   input wire logic [CNNLSF_PSUM_W-1:0] psum,
   input wire logic [CNNLSF_ACC_W-1:0] acc_in,
   // result
   output logic [CNNLSF_ACC_W-1:0] acc_out
);
   logic [CNNLSF_ACC_W-1:0] ext;
   always_comb begin
      // disabled feed forces the added sign-extended value to zero
      ext = en ? {{(CNNLSF_ACC_W-CNNLSF_PSUM_W){psum[CNNLSF_PSUM_W-1]}}, psum} : '0;
      acc_out = acc_in + ext;
   end
endmodule
`default_nettype wire

// file: src/cnnlsf_top.sv
// Purpose: layer control word zero upper fields and sum feed datapath
// Assumes: one quadrant processor, identified by proc_id input
// Notes: results registered one cycle after inputs
// Operation
// [R01] wide bit writes raw 32-bit accumulator
// [R02] feed bits add neighbour 26-bit sums
// [R03] feed bits map rotating from next processor
// [R04] zero feed field zeroes partial sum bus
// [R05] global source bit selects global bus data
// [R06] four global buses, one per processor
// [R07] combined mode shares one sram address
// [R08] combined mode takes data from processor zero; the code does so only when the global source bit is set
// [R09] reserved bits read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none
module cnnlsf_top
   import cnnlsf_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // local processor
   input wire logic [1:0] proc_id,
   input wire logic [CNNLSF_ACC_W-1:0] local_acc,
   input wire logic [CNNLSF_SDATA_W-1:0] scaled_result,
   input wire logic [CNNLSF_ADDR_W-1:0] local_addr,
   // neighbour partial sums indexed by absolute processor number
   input wire logic [CNNLSF_PSUM_W-1:0] psum_in [CNNLSF_NPROC],
   // global data buses driven by each processor
   input wire logic [CNNLSF_SDATA_W-1:0] gbus_in [CNNLSF_NPROC],
   input wire logic [CNNLSF_ADDR_W-1:0] gaddr_in [CNNLSF_NPROC],
   input wire logic combine_all,
   // outputs
   output logic [CNNLSF_SDATA_W-1:0] gbus_out,
   output logic [CNNLSF_PSUM_W-1:0] psum_bus,
   output logic [CNNLSF_ACC_W-1:0] acc_total,
   output logic [CNNLSF_SDATA_W-1:0] sram_wdata,
   output logic [CNNLSF_ADDR_W-1:0] sram_addr,
   output logic [16:0] low_fields
);
   logic [31:0] lcw0_q, lcw0_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic hit, access, done;

   always_comb begin
      hit = (paddr[11:2] == CNNLSF_LCW0_OFFSET[11:2]);
      access = psel && penable && !pready_q;
      done = psel && penable && pready_q;
      lcw0_d = lcw0_q;
      prdata_d = prdata_q;
      pready_d = access;
      pslverr_d = 1'b0;
      if (access) begin
         pslverr_d = !hit;
         prdata_d = 32'h0000_0000;
         if (hit && !pwrite) begin
            prdata_d = lcw0_q & CNNLSF_LCW0_WMASK; // [R09]
         end
      end
      // commit only on the completing edge, so a stretched access never writes early
      if (done && hit && pwrite) begin
         lcw0_d = pwdata & CNNLSF_LCW0_WMASK; // [R09]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lcw0_q <= CNNLSF_LCW0_RESET;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         lcw0_q <= lcw0_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   logic wide_en, gsrc_en;
   logic [3:0] feed_sel;
   always_comb begin
      wide_en = lcw0_q[CNNLSF_WIDE_BIT];
      gsrc_en = lcw0_q[CNNLSF_GSRC_BIT];
      feed_sel = lcw0_q[CNNLSF_FEED_HI:CNNLSF_FEED_LO];
   end

   // neighbour mapping: bit k (1 to 3) selects processor (id+k) mod 4; bit 0 is unused
   logic [CNNLSF_PSUM_W-1:0] nb_psum [1:3];
   logic [CNNLSF_ACC_W-1:0] chain [0:3];
   assign chain[0] = local_acc;
   genvar k;
   generate
      for (k = 1; k < 4; k++) begin : g_feed
         logic [1:0] src;
         assign src = proc_id + 2'(k); // [R03]
         assign nb_psum[k] = psum_in[src];
         cnnlsf_feed_add u_add (
            .en(feed_sel[k]), // [R02]
            .psum(nb_psum[k]),
            .acc_in(chain[k-1]),
            .acc_out(chain[k])
         );
      end
   endgenerate

   logic [CNNLSF_PSUM_W-1:0] psum_bus_q, psum_bus_d;
   logic [CNNLSF_ACC_W-1:0] acc_q, acc_d;
   logic [CNNLSF_SDATA_W-1:0] wdata_q, wdata_d, gbus_q, gbus_d;
   logic [CNNLSF_ADDR_W-1:0] addr_q, addr_d;
   logic [16:0] low_q, low_d;

   always_comb begin
      // bus shows the ored selected sums; zero when the field is clear
      psum_bus_d = '0;
      for (int i = 1; i < 4; i++) begin
         if (feed_sel[i]) begin
            psum_bus_d = psum_bus_d | nb_psum[i];
         end
      end
      if (feed_sel == 4'h0) begin
         psum_bus_d = '0; // [R04]
      end
      acc_d = chain[3]; // [R02]
      gbus_d = wide_en ? local_acc : scaled_result; // [R06]
      if (gsrc_en) begin
         // combined quadrants: processor zero supplies write data
         wdata_d = combine_all ? gbus_in[0] : gbus_in[proc_id]; // [R05] [R08]
      end else begin
         wdata_d = wide_en ? chain[3] : scaled_result; // [R01]
      end
      addr_d = combine_all ? gaddr_in[0] : local_addr; // [R07]
      low_d = lcw0_q[CNNLSF_WIDE_BIT:0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psum_bus_q <= '0;
         acc_q <= '0;
         wdata_q <= '0;
         gbus_q <= '0;
         addr_q <= '0;
         low_q <= '0;
      end else begin
         psum_bus_q <= psum_bus_d;
         acc_q <= acc_d;
         wdata_q <= wdata_d;
         gbus_q <= gbus_d;
         addr_q <= addr_d;
         low_q <= low_d;
      end
   end

   assign psum_bus = psum_bus_q;
   assign acc_total = acc_q;
   assign sram_wdata = wdata_q;
   assign gbus_out = gbus_q;
   assign sram_addr = addr_q;
   assign low_fields = low_q;

   sequence s_apb_acc;
      psel && penable && !pready;
   endsequence

   // a transfer completes on the edge where pready is seen in the access phase
   sequence s_apb_done;
      psel && penable && pready;
   endsequence

   sequence s_apb_wdone;
      s_apb_done ##0 (pwrite && hit);
   endsequence

   sequence s_apb_rd_acc;
      s_apb_acc ##0 (!pwrite && hit);
   endsequence

   a_read_mask: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
      pready && !pwrite && !pslverr |-> prdata[31:17] == 15'h0000)
      else $error("reserved bits read nonzero");
   a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
      s_apb_acc |=> pready)
      else $error("pready late");
   a_write_store: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
      s_apb_wdone |=> lcw0_q == ($past(pwdata) & CNNLSF_LCW0_WMASK))
      else $error("write not stored");
   a_feed_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R04]
      feed_sel == 4'h0 |=> psum_bus == '0)
      else $error("psum bus not zero");
   a_feed_none: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
      feed_sel == 4'h0 |=> acc_total == $past(local_acc))
      else $error("accumulator altered without feed");
   a_wide_write: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
      wide_en && !gsrc_en |=> sram_wdata == $past(acc_d))
      else $error("wide write wrong");
   a_scaled_write: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
      !wide_en && !gsrc_en |=> sram_wdata == $past(scaled_result))
      else $error("scaled write wrong");
   a_gsrc_data: assert property (@(posedge pclk) disable iff (!presetn) // [R05]
      gsrc_en && !combine_all |=> sram_wdata == $past(gbus_in[proc_id]))
      else $error("global source wrong");
   a_comb_addr: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
      combine_all |=> sram_addr == $past(gaddr_in[0]))
      else $error("combined address mismatch");
   a_comb_data: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
      gsrc_en && combine_all |=> sram_wdata == $past(gbus_in[0]))
      else $error("processor zero not source");
   a_map_next: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
      feed_sel == 4'h2 |=> psum_bus == $past(psum_in[proc_id + 2'd1]))
      else $error("rotation mapping wrong");
   a_gbus_drive: assert property (@(posedge pclk) disable iff (!presetn) // [R06]
      !wide_en |=> gbus_out == $past(scaled_result))
      else $error("global bus drive wrong");

   // register and handshake checks
   a_write_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
      !(psel && penable && pready && pwrite && hit) |=> $stable(lcw0_q))
      else $error("register changed without write");
   a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
      lcw0_q[31:CNNLSF_WIDE_BIT+1] == '0)
      else $error("reserved bits stored");
   a_read_data: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
      s_apb_rd_acc |=> prdata == ($past(lcw0_q) & CNNLSF_LCW0_WMASK))
      else $error("read data wrong");
   a_rd_ready: assert property (@(posedge pclk) disable iff (!presetn)
      s_apb_rd_acc |=> pready && !pslverr)
      else $error("read not answered cleanly");
   a_wr_ready: assert property (@(posedge pclk) disable iff (!presetn)
      s_apb_acc ##0 (pwrite && hit) |=> pready && !pslverr)
      else $error("write not answered cleanly");
   a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
      s_apb_acc ##0 (!hit) |=> pslverr)
      else $error("unmapped access without error");
   a_err_data: assert property (@(posedge pclk) disable iff (!presetn)
      s_apb_acc ##0 (!hit) |=> prdata == '0)
      else $error("unmapped read not zero");
   a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error without ready");
   a_err_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |=> !pslverr)
      else $error("error longer than one cycle");
   a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("ready longer than one cycle");
   a_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !psel |=> !pready)
      else $error("ready without request");
   a_low_mirror: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
      1'b1 |=> low_fields == $past(lcw0_q[CNNLSF_WIDE_BIT:0]))
      else $error("low fields mismatch");

   // datapath checks, one cycle after the inputs
   a_map_second: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
      feed_sel == 4'h4 |=> psum_bus == $past(psum_in[proc_id + 2'd2]))
      else $error("second neighbour mapping wrong");
   a_map_third: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
      feed_sel == 4'h8 |=> psum_bus == $past(psum_in[proc_id + 2'd3]))
      else $error("third neighbour mapping wrong");
   a_bit0_unused: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
      feed_sel == 4'h1 |=> psum_bus == '0 && acc_total == $past(local_acc))
      else $error("feed bit zero has effect");
   a_bus_pair: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
      feed_sel == 4'h6 |=> psum_bus == $past(psum_in[proc_id + 2'd1] | psum_in[proc_id + 2'd2]))
      else $error("paired feed bus wrong");
   a_bus_all: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
      feed_sel[3:1] == 3'b111 |=> psum_bus ==
         $past(psum_in[proc_id + 2'd1] | psum_in[proc_id + 2'd2] | psum_in[proc_id + 2'd3]))
      else $error("full feed bus wrong");
   a_feed_one: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
      feed_sel[3:1] == 3'b001 |=> acc_total == $past(local_acc +
         {{(CNNLSF_ACC_W-CNNLSF_PSUM_W){psum_in[proc_id + 2'd1][CNNLSF_PSUM_W-1]}}, psum_in[proc_id + 2'd1]}))
      else $error("first neighbour sum wrong");
   a_feed_two: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
      feed_sel[3:1] == 3'b010 |=> acc_total == $past(local_acc +
         {{(CNNLSF_ACC_W-CNNLSF_PSUM_W){psum_in[proc_id + 2'd2][CNNLSF_PSUM_W-1]}}, psum_in[proc_id + 2'd2]}))
      else $error("second neighbour sum wrong");
   a_feed_three: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
      feed_sel[3:1] == 3'b100 |=> acc_total == $past(local_acc +
         {{(CNNLSF_ACC_W-CNNLSF_PSUM_W){psum_in[proc_id + 2'd3][CNNLSF_PSUM_W-1]}}, psum_in[proc_id + 2'd3]}))
      else $error("third neighbour sum wrong");
   a_addr_local: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
      !combine_all |=> sram_addr == $past(local_addr))
      else $error("local address not used");
   a_gbus_wide: assert property (@(posedge pclk) disable iff (!presetn) // [R06]
      wide_en |=> gbus_out == $past(local_acc))
      else $error("wide global bus drive wrong");
   a_wide_feed: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
      wide_en && !gsrc_en |=> sram_wdata == acc_total)
      else $error("wide write not the full sum");
endmodule
`default_nettype wire

// file: verif/tb.sv
// Purpose: self-checking bench for the layer sum feed control block
// Assumes: apb slave with wait states, datapath outputs one cycle after inputs
// Notes: random configs and datapath values, fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cnnlsf_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, combine_all, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, local_acc, scaled_result, gbus_out, acc_total, sram_wdata, rd, cfg;
   logic [1:0] proc_id;
   logic [16:0] local_addr, sram_addr, low_fields;
   logic [25:0] psum_in [4];
   logic [25:0] psum_bus;
   logic [31:0] gbus_in [4];
   logic [16:0] gaddr_in [4];
   logic [57:0] ex;
   int error_cnt, checks, cyc;
   cnnlsf_top cnnlsf_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .proc_id, .local_acc, .scaled_result, .local_addr, .psum_in, .gbus_in, .gaddr_in,
      .combine_all, .gbus_out, .psum_bus, .acc_total, .sram_wdata, .sram_addr, .low_fields);
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (exp !== got) begin
         error_cnt++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // upper part: or of fed sums, lower part: local plus sign-extended fed sums
   function automatic logic [57:0] exp_sum(input logic [3:0] f, input logic [1:0] id);
      logic [31:0] s;
      logic [25:0] o;
      logic [1:0] j;
      s = local_acc;
      o = 26'h0;
      for (int k = 1; k < 4; k++) begin
         j = id + k[1:0];
         if (f[k]) begin
            s = s + {{6{psum_in[j][25]}}, psum_in[j]};
            o = o | psum_in[j];
         end
      end
      return {o, s};
   endfunction
   task automatic summarize;
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         summarize();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, combine_all, proc_id} = '0;
      {paddr, pwdata, local_acc, scaled_result, local_addr} = '0;
      psum_in = '{default: 26'h0};
      gbus_in = '{default: 32'h0};
      gaddr_in = '{default: 17'h0};
      void'($urandom(32'h9DE0));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, CNNLSF_LCW0_OFFSET, 32'h0);
      chk(CNNLSF_LCW0_RESET, rd);
      apb(1'b1, 12'h594, 32'hFFFF_FFFF);
      chk(32'h1, {31'h0, err});
      apb(1'b0, 12'h594, 32'h0);
      chk(32'h0, rd);
      chk(32'h1, {31'h0, err});
      apb(1'b0, CNNLSF_LCW0_OFFSET, 32'h0);
      chk(32'h0, rd);
      for (int i = 0; i < 40; i++) begin
         cfg = (i == 0) ? 32'hFFFE_0000 : (i == 1) ? 32'hFFFF_F800 : $urandom;
         apb(1'b1, CNNLSF_LCW0_OFFSET, cfg);
         apb(1'b0, CNNLSF_LCW0_OFFSET, 32'h0);
         chk(cfg & 32'h0001_FFFF, rd);
         chk(32'h0, {31'h0, err});
         @(posedge pclk);
         proc_id <= 2'($urandom);
         local_acc <= $urandom;
         scaled_result <= $urandom;
         local_addr <= 17'($urandom);
         combine_all <= 1'($urandom);
         for (int k = 0; k < 4; k++) begin
            psum_in[k] <= 26'($urandom);
            gbus_in[k] <= $urandom;
            gaddr_in[k] <= 17'($urandom);
         end
         @(posedge pclk);
         @(negedge pclk);
         ex = exp_sum(cfg[15:12], proc_id);
         chk({6'h00, ex[57:32]}, {6'h00, psum_bus});
         chk(ex[31:0], acc_total);
         chk(cfg[16] ? local_acc : scaled_result, gbus_out);
         chk({15'h0000, cfg[16:0]}, {15'h0000, low_fields});
         chk({15'h0000, (combine_all ? gaddr_in[0] : local_addr)}, {15'h0000, sram_addr});
         if (cfg[11]) begin
            chk(combine_all ? gbus_in[0] : gbus_in[proc_id], sram_wdata);
         end else begin
            chk(cfg[16] ? ex[31:0] : scaled_result, sram_wdata);
         end
      end
      summarize();
   end
endmodule
`default_nettype wire
